// *** logic/ckg_defines.svh ***
// Register offsets, field positions, reset values and counts for ckg
`ifndef CKG_DEFINES_SVH
`define CKG_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses)
`define CKG_ADDR_W 16
`define CKG_OFF_HS_WAIT_SEL 16'h5061
`define CKG_OFF_HS_WAIT_EN 16'h5062
`define CKG_OFF_OUT_A 16'h5064
`define CKG_OFF_OUT_B 16'h5065
`define CKG_OFF_INTERNAL_OSCILLATOR_FREQ 16'h506E
`define CKG_OFF_PERIPH_GATE 16'h5080
`define CKG_OFF_CORE_GEAR 16'h5081
`define CKG_OFF_STATUS 16'h5090

// ==========================================================
// Field positions
`define CKG_WSEL_LSB 4
`define CKG_WEN_BIT 4
`define CKG_DIV_LSB 4
`define CKG_SRC_LSB 2
`define CKG_OEN_BIT 0

// ==========================================================
// Reset values
`define CKG_RST_WSEL 2'h0
`define CKG_RST_WEN 1'b1
`define CKG_RST_DIV 2'h0
`define CKG_RST_SRC 2'h0
`define CKG_RST_OEN 1'b0
`define CKG_RST_IFREQ 2'h1
`define CKG_RST_PGATE 2'h3
`define CKG_RST_GEAR 2'h0

// ==========================================================
// Codes and counts
`define CKG_PGATE_ON 2'h3
`define CKG_WAIT_MAX 11'h400
`define CKG_WAIT_W 11

`endif

// *** logic/ckg_pkg.sv ***
// Types shared by the clock output and gating block
package ckg_pkg;

   // ==========================================================
   // Register bus request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ckg_bus_t;

   // ==========================================================
   // Oscillator clock levels, sampled in mclk
   typedef struct packed {
      logic internal_oscillator;
      logic hs;
      logic ls;
   } ckg_osc_t;

   // Clock output source codes
   typedef enum logic [1:0] {
      CKG_SRC_INTERNAL_OSCILLATOR = 2'h0,
      CKG_SRC_LS = 2'h1,
      CKG_SRC_HS = 2'h2,
      CKG_SRC_RSVD = 2'h3
   } ckg_src_t;

   // Clock output divider codes
   typedef enum logic [1:0] {
      CKG_DIV_1 = 2'h0,
      CKG_DIV_2 = 2'h1,
      CKG_DIV_4 = 2'h2,
      CKG_DIV_RSVD = 2'h3
   } ckg_div_t;

   // Control fields of one clock output
   typedef struct packed {
      ckg_div_t div;
      ckg_src_t src;
      logic en;
   } ckg_out_cfg_t;

   // Running state of one clock output
   typedef struct packed {
      ckg_out_cfg_t cfg;
      logic level;
      logic phase;
   } ckg_out_st_t;

   // High-speed oscillator stabilisation states
   typedef enum logic [1:0] {
      CKG_HS_OFF,
      CKG_HS_COUNT,
      CKG_HS_READY
   } ckg_hs_state_t;

endpackage

// *** logic/ckg_clock_ctrl.sv ***
// Clock output, stabilisation wait, peripheral gate and core gear logic
//
// Functional notes
// - Wait enabled, oscillator on: hold its clock from system until count elapses.
// - Wait disabled: pass high-speed clock to system at once.
// - Wait select codes 3,2,1,0 give 128,256,512,1024 cycles; reset 0.
// - Output A divider codes 0,1,2 divide by 1,2,4; 3 reserved.
// - Output A ignores divider when low-speed source selected.
// - Output A source: 2 high-speed, 1 low-speed, 0 internal; 3 unused.
// - Output A enable 1 drives clock to pin; 0 stops it.
// - Output B divider codes 0,1,2 divide by 1,2,4; 3 reserved.
// - Output B ignores divider when low-speed source selected.
// - Output B source: 2 high-speed, 1 low-speed, 0 internal; 3 unused.
// - Output B enable 1 drives clock to pin; 0 stops it.
// - Internal frequency select 3,2,1,0 gives 2,4,12,8 MHz; reset 1.
// - Peripheral gate 3 supplies peripheral clock; 0 stops it.
// - Clock outputs and core path do not depend on peripheral clock.
// - Core gear codes 0..3 divide system clock by 1,2,4,8.
//
// Design decision made here: the address-and-strobe port.
`include "ckg_defines.svh"

module ckg_clock_ctrl #(
   parameter int WAIT_W = `CKG_WAIT_W
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire ckg_pkg::ckg_bus_t bus,
   output logic [7:0] rdata,
   input wire ckg_pkg::ckg_osc_t osc,
   input wire logic hs_osc_on,
   input wire logic [1:0] sys_src,
   output logic hs_ready,
   output logic sys_clk_en,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic [1:0] internal_freq_select,
   output logic clock_out_a,
   output logic clock_out_b
);
   import ckg_pkg::*;

   // ==========================================================
   // Helpers

   // Stabilisation length for a wait select code
   function automatic logic [WAIT_W-1:0] wait_len(input logic [1:0] code);
      wait_len = WAIT_W'(`CKG_WAIT_MAX >> code);
   endfunction

   // Next state of one clock output; config is taken only while low
   function automatic ckg_out_st_t out_next(input ckg_out_st_t st,
                                            input ckg_out_cfg_t cfg,
                                            input ckg_osc_t rise,
                                            input ckg_osc_t fall);
      ckg_out_st_t nx;
      logic r;
      logic f;
      logic ev;
      nx = st;
      r = 1'b0;
      f = 1'b0;
      ev = 1'b0;
      case (st.cfg.src)
         CKG_SRC_INTERNAL_OSCILLATOR: begin
            r = rise.internal_oscillator;
            f = fall.internal_oscillator;
         end
         CKG_SRC_LS: begin
            r = rise.ls;
            f = fall.ls;
         end
         CKG_SRC_HS: begin
            r = rise.hs;
            f = fall.hs;
         end
         default: begin
            r = 1'b0;
            f = 1'b0;
         end
      endcase
      if (st.cfg.src == CKG_SRC_LS) begin
         ev = st.level ? f : r;
      end else begin
         case (st.cfg.div)
            CKG_DIV_2: ev = r;
            CKG_DIV_4: ev = r & st.phase;
            default: ev = st.level ? f : r;
         endcase
      end
      if (!st.cfg.en) begin
         // Stopped output rests low and follows config freely
         nx.level = 1'b0;
         nx.phase = 1'b0;
         nx.cfg = cfg;
      end else if (!st.level && !ev && !r) begin
         // Low half boundary: safe to adopt new settings
         nx.cfg = cfg;
      end
      if (st.cfg.en) begin
         if (r && st.cfg.div == CKG_DIV_4) begin
            nx.phase = ~st.phase;
         end
         if (ev) begin
            nx.level = ~st.level;
         end
      end
      return nx;
   endfunction

   // ==========================================================
   // Registers
   logic [1:0] wait_sel_q;
   logic wait_en_q;
   ckg_out_cfg_t cfg_a_q;
   ckg_out_cfg_t cfg_b_q;
   logic [1:0] ifreq_q;
   logic [1:0] pgate_q;
   logic [1:0] gear_q;

   // Software writes; reserved bits are dropped
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wait_sel_q <= `CKG_RST_WSEL;
         wait_en_q <= `CKG_RST_WEN;
         cfg_a_q <= '{div: ckg_div_t'(`CKG_RST_DIV),
                      src: ckg_src_t'(`CKG_RST_SRC), en: `CKG_RST_OEN};
         cfg_b_q <= '{div: ckg_div_t'(`CKG_RST_DIV),
                      src: ckg_src_t'(`CKG_RST_SRC), en: `CKG_RST_OEN};
         ifreq_q <= `CKG_RST_IFREQ;
         pgate_q <= `CKG_RST_PGATE;
         gear_q <= `CKG_RST_GEAR;
      end else if (bus.wr) begin
         case (bus.addr)
            `CKG_OFF_HS_WAIT_SEL:
               wait_sel_q <= bus.wdata[`CKG_WSEL_LSB +: 2];
            `CKG_OFF_HS_WAIT_EN: wait_en_q <= bus.wdata[`CKG_WEN_BIT];
            `CKG_OFF_OUT_A: begin
               cfg_a_q.div <= ckg_div_t'(bus.wdata[`CKG_DIV_LSB +: 2]);
               cfg_a_q.src <= ckg_src_t'(bus.wdata[`CKG_SRC_LSB +: 2]);
               cfg_a_q.en <= bus.wdata[`CKG_OEN_BIT];
            end
            `CKG_OFF_OUT_B: begin
               cfg_b_q.div <= ckg_div_t'(bus.wdata[`CKG_DIV_LSB +: 2]);
               cfg_b_q.src <= ckg_src_t'(bus.wdata[`CKG_SRC_LSB +: 2]);
               cfg_b_q.en <= bus.wdata[`CKG_OEN_BIT];
            end
            `CKG_OFF_INTERNAL_OSCILLATOR_FREQ: ifreq_q <= bus.wdata[1:0];
            // Codes 2 and 1 are software's to avoid; stored as written
            `CKG_OFF_PERIPH_GATE: pgate_q <= bus.wdata[1:0];
            `CKG_OFF_CORE_GEAR: gear_q <= bus.wdata[1:0];
            default: ;
         endcase
      end
   end

   assign internal_freq_select = ifreq_q;

   // ==========================================================
   // Oscillator edge detection
   ckg_osc_t osc_q;
   ckg_osc_t rise;
   ckg_osc_t fall;

   // Inputs are synchronous, one stage suffices for edges
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         osc_q <= '0;
      end else begin
         osc_q <= osc;
      end
   end

   assign rise = osc & ~osc_q;
   assign fall = ~osc & osc_q;

   // ==========================================================
   // High-speed stabilisation wait
   ckg_hs_state_t hs_st_q;
   logic [WAIT_W-1:0] wait_cnt_q;

   // Counts oscillator cycles from switch-on; an off restarts it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         hs_st_q <= CKG_HS_OFF;
         wait_cnt_q <= '0;
      end else begin
         case (hs_st_q)
            CKG_HS_OFF: begin
               wait_cnt_q <= '0;
               if (hs_osc_on) begin
                  hs_st_q <= wait_en_q ? CKG_HS_COUNT : CKG_HS_READY;
               end
            end
            CKG_HS_COUNT: begin
               if (!hs_osc_on) begin
                  hs_st_q <= CKG_HS_OFF;
               end else if (!wait_en_q) begin
                  hs_st_q <= CKG_HS_READY;
               end else if (rise.hs) begin
                  wait_cnt_q <= wait_cnt_q + 1'b1;
                  if (wait_cnt_q + 1'b1 >= wait_len(wait_sel_q)) begin
                     hs_st_q <= CKG_HS_READY;
                  end
               end
            end
            CKG_HS_READY: begin
               if (!hs_osc_on) begin
                  hs_st_q <= CKG_HS_OFF;
               end
            end
            default: hs_st_q <= CKG_HS_OFF;
         endcase
      end
   end

   assign hs_ready = (hs_st_q == CKG_HS_READY);

   // ==========================================================
   // System, peripheral and core clock enables
   logic sys_tick;
   logic [2:0] gear_cnt_q;
   logic [1:0] gear_act_q;
   logic [2:0] gear_top;

   // Held-back high-speed clock never reaches the system
   always_comb begin
      case (ckg_src_t'(sys_src))
         CKG_SRC_INTERNAL_OSCILLATOR: sys_tick = rise.internal_oscillator;
         CKG_SRC_LS: sys_tick = rise.ls;
         CKG_SRC_HS: sys_tick = rise.hs & hs_ready;
         default: sys_tick = 1'b0;
      endcase
   end

   assign gear_top = 3'((4'h1 << gear_act_q) - 4'h1);

   // New ratio adopted only at period end, so no short core cycle
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         gear_cnt_q <= '0;
         gear_act_q <= `CKG_RST_GEAR;
      end else if (sys_tick) begin
         if (gear_cnt_q >= gear_top) begin
            gear_cnt_q <= '0;
            gear_act_q <= gear_q;
         end else begin
            gear_cnt_q <= gear_cnt_q + 1'b1;
         end
      end
   end

   // Enables are handshake-like pulses, one mclk each
   assign sys_clk_en = sys_tick;
   assign core_clk_en = sys_tick & (gear_cnt_q >= gear_top);
   assign periph_clk_en = sys_tick & (pgate_q == `CKG_PGATE_ON);

   // ==========================================================
   // External clock outputs, independent of the peripheral gate
   ckg_out_st_t out_a_q;
   ckg_out_st_t out_b_q;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         out_a_q <= '0;
      end else begin
         out_a_q <= out_next(out_a_q, cfg_a_q, rise, fall);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         out_b_q <= '0;
      end else begin
         out_b_q <= out_next(out_b_q, cfg_b_q, rise, fall);
      end
   end

   assign clock_out_a = out_a_q.level;
   assign clock_out_b = out_b_q.level;

   // ==========================================================
   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            `CKG_OFF_HS_WAIT_SEL: rdata <= {2'h0, wait_sel_q, 4'h0};
            `CKG_OFF_HS_WAIT_EN: rdata <= {3'h0, wait_en_q, 4'h0};
            `CKG_OFF_OUT_A:
               rdata <= {2'h0, cfg_a_q.div, cfg_a_q.src, 1'b0, cfg_a_q.en};
            `CKG_OFF_OUT_B:
               rdata <= {2'h0, cfg_b_q.div, cfg_b_q.src, 1'b0, cfg_b_q.en};
            `CKG_OFF_INTERNAL_OSCILLATOR_FREQ: rdata <= {6'h00, ifreq_q};
            `CKG_OFF_PERIPH_GATE: rdata <= {6'h00, pgate_q};
            `CKG_OFF_CORE_GEAR: rdata <= {6'h00, gear_q};
            `CKG_OFF_STATUS:
               rdata <= {5'h00, out_b_q.level, out_a_q.level, hs_ready};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule

// *** test/ckg_clock_ctrl_properties.sv ***
// Port-level checks for the clock output and gating block
module ckg_clock_ctrl_properties #(
   parameter int WAIT_W = 11
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire ckg_pkg::ckg_bus_t bus,
   input wire logic [7:0] rdata,
   input wire ckg_pkg::ckg_osc_t osc,
   input wire logic hs_osc_on,
   input wire logic [1:0] sys_src,
   input wire logic hs_ready,
   input wire logic sys_clk_en,
   input wire logic periph_clk_en,
   input wire logic [1:0] internal_freq_select,
   input wire logic clock_out_a,
   input wire logic clock_out_b
);
   timeunit 1ns;
   timeprecision 1ns;
   import ckg_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Shadow state
   logic a_en_q, b_en_q, wen_q, hs_prev_q;
   logic [1:0] pg_q, wsel_q;
   logic [5:0] a_off_q, b_off_q;
   logic [11:0] rise_q, need;
   assign need = 12'h400 >> wsel_q;
   // Control bits, taken from the same writes the block sees
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         a_en_q <= 1'b0;
         b_en_q <= 1'b0;
         wen_q <= 1'b1;
         pg_q <= 2'h3;
         wsel_q <= 2'h0;
      end else if (bus.wr) begin
         if (bus.addr == 16'h5064) a_en_q <= bus.wdata[0];
         if (bus.addr == 16'h5065) b_en_q <= bus.wdata[0];
         if (bus.addr == 16'h5062) wen_q <= bus.wdata[4];
         if (bus.addr == 16'h5080) pg_q <= bus.wdata[1:0];
         if (bus.addr == 16'h5061) wsel_q <= bus.wdata[5:4];
      end
   end
   // Cycles spent disabled; 63 outlasts any pulse still in flight
   always_ff @(posedge mclk) begin
      if (!rstn || a_en_q) a_off_q <= 6'h00;
      else if (a_off_q != 6'h3F) a_off_q <= a_off_q + 6'h01;
      if (!rstn || b_en_q) b_off_q <= 6'h00;
      else if (b_off_q != 6'h3F) b_off_q <= b_off_q + 6'h01;
   end
   // Oscillator rises seen since switch-on
   always_ff @(posedge mclk) begin
      hs_prev_q <= osc.hs;
      if (!rstn || !hs_osc_on) rise_q <= 12'h000;
      else if (osc.hs && !hs_prev_q) rise_q <= rise_q + 12'h001;
   end
   // ==========================================================
   // Properties
   sequence s_gate_read;
      bus.rd && bus.addr == 16'h5080;
   endsequence
   sequence s_freq_write;
      bus.wr && bus.addr == 16'h506E;
   endsequence
   AST_RD_GATE: assert property (
      s_gate_read |=> rdata == {6'h00, pg_q})
      else $error("gate read mismatch");
   AST_IFREQ: assert property (s_freq_write |=>
      {6'h00, internal_freq_select} == ($past(bus.wdata) & 8'h03))
      else $error("frequency select not taken");
   AST_PGATE: assert property (
      periph_clk_en == (sys_clk_en && pg_q == 2'h3))
      else $error("peripheral clock gating wrong");
   AST_HS_OFF: assert property (!hs_osc_on |=> !hs_ready)
      else $error("ready while oscillator off");
   AST_HS_HOLD: assert property (
      hs_ready && wen_q |-> rise_q + 12'h001 >= need)
      else $error("released before wait count");
   AST_HS_NOWAIT: assert property (
      !wen_q && $rose(hs_osc_on) |-> ##[1:2] hs_ready)
      else $error("no prompt release without wait");
   AST_SYS_HS: assert property (
      sys_src == 2'h2 && !hs_ready |-> !sys_clk_en)
      else $error("system tick before release");
   AST_OUTA_OFF: assert property (
      a_off_q == 6'h3F |-> !clock_out_a)
      else $error("output A runs while disabled");
   AST_OUTB_OFF: assert property (
      b_off_q == 6'h3F |-> !clock_out_b)
      else $error("output B runs while disabled");
endmodule

// *** test/ckg_clock_ctrl_bench.sv ***
// Self-checking bench for the clock output and gating block
module ckg_clock_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import ckg_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   ckg_bus_t bus = '0;
   ckg_osc_t osc = '0;
   logic hs_osc_on = 1'b0;
   logic [1:0] sys_src = 2'h0;
   logic [7:0] rdata;
   logic [1:0] ifs;
   logic hs_ready, sys_en, core_en, per_en, out_a, out_b;
   int fails = 0;
   int tests_run = 0;
   int tick = 0;
   int na, nb, nc, np, ns, n;
   // Address, write data, expected read-back
   logic [31:0] rows [8] = '{32'h5064FF3D,
      32'h5065FF3D, 32'h506EFE02, 32'h50800000,
      32'h5080FF03, 32'h5081FF03, 32'h5061FF30, 32'h5070FF00};
   // Disable flag, source, divider, rises of the output in 240 cycles
   logic [15:0] orow [9] = '{16'h203C, 16'h211E, 16'h220F, 16'h1218,
      16'h0028, 16'h0114, 16'h020A, 16'h3000, 16'h8200};
   always #50 mclk = ~mclk;
   // Oscillators with periods of 6, 4 and 10 cycles
   always @(posedge mclk) begin
      tick <= tick + 1;
      osc <= {tick % 6 < 3, tick % 4 < 2, tick % 10 < 5};
   end
   ckg_clock_ctrl i_ckg_clock_ctrl (.mclk(mclk), .rstn(rstn), .bus(bus),
      .rdata(rdata), .osc(osc), .hs_osc_on(hs_osc_on), .sys_src(sys_src),
      .hs_ready(hs_ready), .sys_clk_en(sys_en), .core_clk_en(core_en),
      .periph_clk_en(per_en), .internal_freq_select(ifs),
      .clock_out_a(out_a), .clock_out_b(out_b));
   // ==========================================================
   // Tasks
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      @(negedge mclk);
      chk({8'h00, rdata}, {8'h00, e});
   endtask
   // Settle, then count output rises and tick pulses over 240 cycles
   task automatic meas;
      logic pa, pb;
      repeat (64) @(posedge mclk);
      @(negedge mclk);
      {pa, pb, na, nb, nc, np, ns} = {out_a, out_b, 160'h0};
      repeat (240) begin
         @(negedge mclk);
         na += int'(out_a && !pa);
         nb += int'(out_b && !pb);
         {pa, pb} = {out_a, out_b};
         nc += int'(core_en);
         np += int'(per_en);
         ns += int'(sys_en);
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      foreach (rows[k]) begin
         wr(rows[k][31:16], rows[k][15:8]);
         rd(rows[k][31:16], rows[k][7:0]);
      end
      wr(16'h5080, 8'h00);
      foreach (orow[k]) begin
         wr(16'h5064, {2'h0, orow[k][9:8], orow[k][13:12], 2'(!orow[k][15])});
         wr(16'h5065, {2'h0, orow[8-k][9:8], orow[8-k][13:12], 1'b0,
            !orow[8-k][15]});
         meas;
         chk(16'(na), 16'(orow[k][7:0]));
         chk(16'(nb), 16'(orow[8-k][7:0]));
         chk(16'(np), 16'h0000);
      end
      wr(16'h5080, 8'h03);
      for (int g = 0; g < 4; g++) begin
         wr(16'h5081, 8'(g));
         meas;
         chk(16'(nc), 16'(40 >> g));
         chk(16'(np), 16'd40);
      end
      wr(16'h5081, 8'h00);
      sys_src <= 2'h2;
      for (int c = 3; c >= 0; c--) begin
         wr(16'h5061, 8'(c << 4));
         hs_osc_on <= 1'b1;
         n = 0;
         while (hs_ready !== 1'b1 && n < 5000) begin
            @(posedge mclk);
            n++;
         end
         if (n == 5000) begin
            fails++;
            tally_and_finish;
         end
         chk(16'(n >= (4096 >> c) - 4 && n <= (4096 >> c) + 4),
            16'h1);
         meas;
         chk(16'(ns), 16'd60);
         // Stimulus moves only on the rising edge
         @(posedge mclk);
         hs_osc_on <= 1'b0;
         repeat (4) @(posedge mclk);
      end
      wr(16'h5062, 8'h00);
      hs_osc_on <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({15'h0, hs_ready}, 16'h1);
      @(posedge mclk);
      hs_osc_on <= 1'b0;
      rstn <= 1'b0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      // Look at reset outputs away from the edge that launches them
      @(negedge mclk);
      chk({12'h0, ifs, out_a, out_b}, 16'h4);
      rd(16'h5064, 8'h00);
      rd(16'h5065, 8'h00);
      rd(16'h5080, 8'h03);
      rd(16'h5081, 8'h00);
      rd(16'h5061, 8'h00);
      rd(16'h5062, 8'h10);
      rd(16'h5090, 8'h00);
      tally_and_finish;
   end
endmodule
bind ckg_clock_ctrl ckg_clock_ctrl_properties #(.WAIT_W(WAIT_W)) i_props (
   .mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .osc(osc),
   .hs_osc_on(hs_osc_on), .sys_src(sys_src), .hs_ready(hs_ready),
   .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
   .internal_freq_select(internal_freq_select),
   .clock_out_a(clock_out_a), .clock_out_b(clock_out_b));
